// [pex_access.sv]
// serial target access logic of the two-group port expander
//
// Contract
// - group A one-byte read: inputs and output pins; clear flags, release int
// - group B one-byte read returns all eight output pin levels
// - group A two-byte read: port data, then flags from before clearing
// - longer group A reads alternate data/flags, resampling each pair
// - masked change during a read raises int at stop
// - no further interrupt asserted while any read runs
// - input data captured during the acknowledge before its byte
// - group B longer reads resample pins at each acknowledge
// - group A write byte sets four outputs and mask; write address ack snapshots, clears flags
// - group B write byte sets all eight outputs, each replacing last
// - group A read address: ack, snapshot during ack, release int
// - master not-acknowledge: no snapshot, interrupt unchanged
// - released interrupt stays off until stop during group A read
// - new snapshot equals transmitted port data
// - group B readback shows real pin levels, not latches
// - group A answers 110xxxx, group B 101xxxx; low bits from pins
// - transition flag sets on change versus snapshot, stays until cleared
// - only masked inputs raise interrupt; flags set regardless
`timescale 1ns/100ps
`default_nettype none
module pex_access #(
   parameter int FIFO_DEPTH = pex_pkg::PEX_FIFO_DEPTH
) (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   output logic            int_n_out,
   output logic            int_n_oe_out,
   input  wire logic [1:0] addr_sel_pin_high_in,
   input  wire logic [1:0] addr_sel_pin_low_in,
   input  wire logic [3:0] input_ports_in,
   input  wire logic [3:0] group_a_pin_in,
   input  wire logic [7:0] group_b_pin_in,
   input  wire logic       outputs_hold_in,
   output logic [3:0]      group_a_outputs_out,
   output logic [7:0]      group_b_outputs_out,
   output logic [3:0]      int_mask_out
);
   import pex_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      pex_pins_t  s1;
      pex_pins_t  s2;
      pex_pins_t  s3;
      pex_pins_t  f;
      pex_state_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic       sda_oe;
      logic       grp_b;
      logic       rd;
      logic       pair;
      logic [3:0] snap;
      logic [3:0] flags;
      logic [3:0] flags_old;
      logic       int_q;
      logic [3:0] mask;
      logic [3:0] ga_out;
      logic [7:0] gb_out;
   } pex_st_t;

   pex_st_t    q;
   pex_st_t    d;
   pex_pins_t  pins;
   pex_pins_t  f_n;
   logic [$bits(pex_pins_t)-1:0] agree;
   logic       rise;
   logic       fall;
   logic       start_ev;
   logic       stop_ev;
   logic       hit_a;
   logic       hit_b;
   logic       snap_now;
   logic [3:0] mism;
   pex_wr_t    push_data;
   logic       push;
   logic       fifo_rdy;
   pex_wr_t    pop_data;
   logic       pop_valid;
   logic       pop;

   function automatic logic [7:0] ga_byte(input logic [3:0] inp,
                                          input logic [3:0] pin);
      ga_byte = {pin[3:2], inp, pin[1:0]};
   endfunction : ga_byte

   // ---------------------------------------------------------------
   // pin filtering and bus events
   // ---------------------------------------------------------------
   assign pins  = '{scl: scl_in, sda: sda_in, inp: input_ports_in,
                    ga_pin: group_a_pin_in, gb_pin: group_b_pin_in,
                    adr: {addr_sel_pin_high_in, addr_sel_pin_low_in}};
   // a bit moves only when stages two and three agree
   assign agree = ~(q.s2 ^ q.s3);
   assign f_n   = pex_pins_t'((agree & q.s3) | (~agree & q.f));
   assign rise     = !q.f.scl && f_n.scl;
   assign fall     = q.f.scl && !f_n.scl;
   assign start_ev = q.f.scl && f_n.scl && q.f.sda && !f_n.sda;
   assign stop_ev  = q.f.scl && f_n.scl && !q.f.sda && f_n.sda;
   assign hit_a = (q.sh[7:5] == PEX_GA_ADDR_HI) && (q.sh[4:1] == q.f.adr);
   assign hit_b = (q.sh[7:5] == PEX_GB_ADDR_HI) && (q.sh[4:1] == q.f.adr);
   assign pop   = pop_valid && !outputs_hold_in;
   assign push_data = '{grp_b: q.grp_b, data: q.sh};

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      d        = q;
      snap_now = 1'b0;
      push     = 1'b0;
      mism     = '0;
      d.s1 = pins;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.f  = f_n;
      if (stop_ev) begin
         d.st     = PEX_IDLE;
         d.sda_oe = 1'b0;
         d.rd     = 1'b0;
         if (q.rd && |(q.flags & q.mask)) begin
            d.int_q = 1'b1;
         end
      end else if (start_ev) begin
         d.st     = PEX_ADDR;
         d.cnt    = '0;
         d.sda_oe = 1'b0;
         d.rd     = 1'b0;
      end else begin
         case (q.st)
            PEX_ADDR: begin
               if (rise) begin
                  d.sh  = {q.sh[6:0], f_n.sda};
                  d.cnt = q.cnt + 4'h1;
               end
               if (fall && q.cnt == PEX_BIT_CNT) begin
                  if (hit_a || hit_b) begin
                     d.st     = PEX_ADDR_ACK;
                     d.sda_oe = 1'b1;
                     d.grp_b  = hit_b;
                     d.rd     = q.sh[0];
                  end else begin
                     d.st = PEX_IGNORE;
                  end
               end
            end
            PEX_ADDR_ACK: begin
               if (rise) begin
                  snap_now = !q.grp_b;
                  d.pair   = 1'b1;
                  if (q.grp_b) begin
                     d.sh = f_n.gb_pin;
                  end else begin
                     d.sh = ga_byte(f_n.inp, f_n.ga_pin);
                  end
               end
               if (fall) begin
                  d.cnt    = '0;
                  d.st     = q.rd ? PEX_RD_DATA : PEX_WR_DATA;
                  d.sda_oe = q.rd && !q.sh[7];
               end
            end
            PEX_WR_DATA: begin
               if (rise) begin
                  d.sh  = {q.sh[6:0], f_n.sda};
                  d.cnt = q.cnt + 4'h1;
               end
               if (fall && q.cnt == PEX_BIT_CNT) begin
                  // a full fifo refuses the byte with a not-acknowledge
                  if (fifo_rdy) begin
                     push     = 1'b1;
                     d.sda_oe = 1'b1;
                     d.st     = PEX_WR_ACK;
                  end else begin
                     d.st = PEX_IGNORE;
                  end
               end
            end
            PEX_WR_ACK: begin
               if (fall) begin
                  d.sda_oe = 1'b0;
                  d.cnt    = '0;
                  d.st     = PEX_WR_DATA;
               end
            end
            PEX_RD_DATA: begin
               if (rise) begin
                  d.cnt = q.cnt + 4'h1;
               end
               if (fall) begin
                  if (q.cnt == PEX_BIT_CNT) begin
                     d.sda_oe = 1'b0;
                     d.st     = PEX_RD_ACK;
                  end else begin
                     d.sh     = {q.sh[6:0], 1'b0};
                     d.sda_oe = !q.sh[6];
                  end
               end
            end
            PEX_RD_ACK: begin
               if (rise) begin
                  if (f_n.sda) begin
                     d.st = PEX_IGNORE;
                  end else if (q.grp_b) begin
                     d.sh = f_n.gb_pin;
                  end else if (q.pair) begin
                     d.sh   = {2'b00, q.flags_old, 2'b00};
                     d.pair = 1'b0;
                  end else begin
                     snap_now = 1'b1;
                     d.sh     = ga_byte(f_n.inp, f_n.ga_pin);
                     d.pair   = 1'b1;
                  end
               end
               if (fall) begin
                  d.cnt    = '0;
                  d.st     = PEX_RD_DATA;
                  d.sda_oe = !q.sh[7];
               end
            end
            default: begin
            end
         endcase
      end
      // snapshot, flags and interrupt
      if (snap_now) begin
         d.snap      = f_n.inp;
         d.flags_old = q.flags;
         d.flags     = '0;
         d.int_q     = 1'b0;
      end
      mism    = f_n.inp ^ d.snap;
      d.flags = d.flags | mism;                           // set wins
      if (!d.rd && |(mism & d.mask)) begin
         d.int_q = 1'b1;
      end
      // output latches follow the drained write bytes
      if (pop) begin
         if (pop_data.grp_b) begin
            d.gb_out = pop_data.data;
         end else begin
            d.ga_out = {pop_data.data[PEX_GA_HI_POS+:2],
                        pop_data.data[PEX_GA_LO_POS+:2]};
            d.mask   = pop_data.data[PEX_GA_IN_POS+:4];
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q        <= '0;
         q.s1     <= '1;
         q.s2     <= '1;
         q.s3     <= '1;
         q.f      <= '1;
         q.st     <= PEX_IDLE;
         q.mask   <= PEX_MASK_RST;
         q.ga_out <= PEX_GA_OUT_RST;
         q.gb_out <= PEX_GB_OUT_RST;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // write buffer
   // ---------------------------------------------------------------
   pex_fifo #(
      .W     ($bits(pex_wr_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .in_valid_in   (push),
      .in_ready_out  (fifo_rdy),
      .in_data_in    (push_data),
      .out_valid_out (pop_valid),
      .out_ready_in  (!outputs_hold_in),
      .out_data_out  (pop_data)
   );

   assign sda_out             = 1'b0;
   assign sda_oe_out          = q.sda_oe;
   assign int_n_out           = 1'b0;
   assign int_n_oe_out        = q.int_q;
   assign group_a_outputs_out = q.ga_out;
   assign group_b_outputs_out = q.gb_out;
   assign int_mask_out        = q.mask;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_ga_rd_ack;
      q.st == PEX_ADDR_ACK && rise && !q.grp_b && q.rd;
   endsequence
   sequence s_master_ack;
      q.st == PEX_RD_ACK && rise && !f_n.sda;
   endsequence

   property p_snap_tx;
      s_ga_rd_ack |=> (q.snap == q.sh[PEX_GA_IN_POS+:4]) && !q.int_q;
   endproperty
   a_snap_tx: assert property (p_snap_tx)
      else $error("snapshot differs from sent port data");
   property p_no_int_in_read;
      (q.rd && !stop_ev) |=> !$rose(q.int_q);
   endproperty
   a_no_int_in_read: assert property (p_no_int_in_read)
      else $error("interrupt raised during a read");
   property p_int_at_stop;
      (stop_ev && q.rd && |(q.flags & q.mask)) |=> q.int_q;
   endproperty
   a_int_at_stop: assert property (p_int_at_stop)
      else $error("deferred interrupt missing at stop");
   property p_nack;
      (q.st == PEX_RD_ACK && rise && f_n.sda && !stop_ev) |=>
         q.st == PEX_IGNORE && $stable(q.snap) && $stable(q.int_q);
   endproperty
   a_nack: assert property (p_nack)
      else $error("not-acknowledge changed snapshot or interrupt");
   property p_flag_sticky;
      !snap_now |=> (q.flags & $past(q.flags)) == $past(q.flags);
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("transition flag dropped without an access");
   property p_int_masked;
      $rose(q.int_q) |-> |(q.flags & q.mask);
   endproperty
   a_int_masked: assert property (p_int_masked)
      else $error("interrupt without a masked flag");
   property p_foreign;
      (q.st == PEX_ADDR && fall && q.cnt == PEX_BIT_CNT && !hit_a &&
       !hit_b && !stop_ev && !start_ev) |=>
         q.st == PEX_IGNORE && !q.sda_oe;
   endproperty
   a_foreign: assert property (p_foreign)
      else $error("foreign address acknowledged");
   property p_gb_resample;
      s_master_ack ##0 (q.grp_b && !stop_ev) |=>
         q.sh == $past(f_n.gb_pin);
   endproperty
   a_gb_resample: assert property (p_gb_resample)
      else $error("group B byte not resampled from pins");
   property p_flags_second;
      s_master_ack ##0 (!q.grp_b && q.pair && !stop_ev) |=>
         q.sh == {2'b00, $past(q.flags_old), 2'b00};
   endproperty
   a_flags_second: assert property (p_flags_second)
      else $error("flag byte not the pre-clear flags");
endmodule : pex_access
`default_nettype wire

// [pex_pkg.sv]
// shared constants and types of the port expander access block
package pex_pkg;
   // ---------------------------------------------------------------
   // addresses and byte layout
   // ---------------------------------------------------------------
   localparam logic [2:0] PEX_GA_ADDR_HI = 3'h6;  // 1,1,0
   localparam logic [2:0] PEX_GB_ADDR_HI = 3'h5;  // 1,0,1
   localparam int         PEX_BYTE_W     = 8;
   localparam logic [3:0] PEX_BIT_CNT    = 4'h8;
   localparam int         PEX_GA_LO_POS  = 0;     // outputs zero, one
   localparam int         PEX_GA_IN_POS  = 2;     // inputs / flags / mask
   localparam int         PEX_GA_HI_POS  = 6;     // outputs six, seven
   // ---------------------------------------------------------------
   // reset values and buffering
   // ---------------------------------------------------------------
   localparam logic [3:0] PEX_GA_OUT_RST = 4'hF;
   localparam logic [7:0] PEX_GB_OUT_RST = 8'hFF;
   localparam logic [3:0] PEX_MASK_RST   = 4'h0;
   localparam int         PEX_FIFO_DEPTH = 8;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      PEX_IDLE     = 3'b000,
      PEX_ADDR     = 3'b001,
      PEX_ADDR_ACK = 3'b010,
      PEX_WR_DATA  = 3'b011,
      PEX_WR_ACK   = 3'b100,
      PEX_RD_DATA  = 3'b101,
      PEX_RD_ACK   = 3'b110,
      PEX_IGNORE   = 3'b111
   } pex_state_t;

   typedef struct packed {
      logic       grp_b;
      logic [7:0] data;
   } pex_wr_t;

   typedef struct packed {
      logic       scl;
      logic       sda;
      logic [3:0] inp;
      logic [3:0] ga_pin;
      logic [7:0] gb_pin;
      logic [3:0] adr;
   } pex_pins_t;
endpackage : pex_pkg

// [pex_fifo.sv]
// write-byte fifo between the serial receiver and the output latches
`timescale 1ns/100ps
`default_nettype none
module pex_fifo #(
   parameter int W     = 9,
   parameter int DEPTH = 8
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         in_valid_in,
   output logic              in_ready_out,
   input  wire logic [W-1:0] in_data_in,
   output logic              out_valid_out,
   input  wire logic         out_ready_in,
   output logic [W-1:0]      out_data_out
);
   import pex_pkg::*;
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_chk
         $error("pex_fifo: DEPTH must be a power of two >= 2");
      end
   endgenerate

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } pex_fifo_st_t;

   pex_fifo_st_t q;
   pex_fifo_st_t d;
   logic [W-1:0] mem [DEPTH];
   logic         full;
   logic         empty;
   logic         wr;
   logic         rd;

   assign full          = (q.wp[AW] != q.rp[AW]) &&
                          (q.wp[AW-1:0] == q.rp[AW-1:0]);
   assign empty         = (q.wp == q.rp);
   assign in_ready_out  = !full;
   assign out_valid_out = !empty;
   assign out_data_out  = mem[q.rp[AW-1:0]];
   assign wr            = in_valid_in && !full;
   assign rd            = out_ready_in && !empty;

   always_comb begin
      d = q;
      if (wr) begin
         d.wp = q.wp + 1'b1;
      end
      if (rd) begin
         d.rp = q.rp + 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // storage has no reset: only entries below wp are ever read
   always_ff @(posedge clk_in) begin
      if (wr) begin
         mem[q.wp[AW-1:0]] <= in_data_in;
      end
   end
endmodule : pex_fifo
`default_nettype wire

// [pex_i2c_master.sv]
// two-wire bus master model facing the expander's serial port
`timescale 1ns/100ps
`default_nettype none
module pex_i2c_master (
   input  wire logic  clk_in,
   input  wire logic  sda_oe_in,
   output logic       scl_out,
   output logic       sda_out,
   output logic       rx_valid_out,
   output logic [7:0] rx_byte_out
);
   logic sda_low_q;
   // ---------------------------------------------------------------
   // wire with pull-up: released means high
   // ---------------------------------------------------------------
   assign sda_out = ~(sda_low_q | sda_oe_in);
   initial begin
      scl_out      = 1'b1;
      sda_low_q    = 1'b0;
      rx_valid_out = 1'b0;
      rx_byte_out  = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick
   // data moves a quarter into low phase; line sampled mid high phase
   task automatic bit_io(input logic b, output logic r);
      tick(2);
      sda_low_q <= ~b;
      tick(6);
      scl_out <= 1'b1;
      tick(4);
      r = sda_out;
      tick(4);
      scl_out <= 1'b0;
   endtask : bit_io
   task automatic start();
      tick(2);
      sda_low_q <= 1'b0;
      tick(6);
      scl_out <= 1'b1;
      tick(8);
      sda_low_q <= 1'b1;
      tick(8);
      scl_out <= 1'b0;
   endtask : start
   // clock left standing high afterwards, bus idle
   task automatic stop();
      tick(2);
      sda_low_q <= 1'b1;
      tick(6);
      scl_out <= 1'b1;
      tick(8);
      sda_low_q <= 1'b0;
      tick(8);
   endtask : stop
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask : write_byte
   task automatic read_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(~ack, r);
      rx_byte_out  <= d;
      rx_valid_out <= 1'b1;
      tick(1);
      rx_valid_out <= 1'b0;
   endtask : read_byte
endmodule : pex_i2c_master
`default_nettype wire

// [pex_access_bench.sv]
// self-checking bench of the expander access block
`timescale 1ns/100ps
`default_nettype none
module pex_access_bench;
   import pex_pkg::*;
   logic       clk_in, rst_n_in, scl, sda, sda_o, sda_oe, int_n, int_oe;
   logic       hold, rx_valid, a;
   logic [1:0] adr_hi, adr_lo;
   logic [3:0] inp, ga_pin, ga_out, mask, in_cur;
   logic [7:0] gb_pin, gb_out, rx_byte, cur, d, gp;
   logic [7:0] wbuf [0:8];
   logic [7:0] exp_q [$];
   int         num_errors = 0;
   int         checks = 0;

   pex_access #(.FIFO_DEPTH(8)) pex_access_i (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_o), .sda_oe_out(sda_oe), .int_n_out(int_n),
      .int_n_oe_out(int_oe), .addr_sel_pin_high_in(adr_hi),
      .addr_sel_pin_low_in(adr_lo), .input_ports_in(inp),
      .group_a_pin_in(ga_pin), .group_b_pin_in(gb_pin),
      .outputs_hold_in(hold), .group_a_outputs_out(ga_out),
      .group_b_outputs_out(gb_out), .int_mask_out(mask));
   pex_i2c_master pex_i2c_master_i (
      .clk_in(clk_in), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda),
      .rx_valid_out(rx_valid), .rx_byte_out(rx_byte));

   initial clk_in = 1'b0;
   always #2 clk_in = ~clk_in;
   // ---------------------------------------------------------------
   // compare and closing tasks
   // ---------------------------------------------------------------
   task automatic cmp8(input string what, input logic [7:0] e, g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask : cmp8
   task automatic cmp1(input string what, input logic e, g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, e, g);
      end
   endtask : cmp1
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick
   // bounded wait; interrupt must settle within 20 clocks
   task automatic wait_int(input logic e);
      for (int n = 0; n < 20 && int_oe !== e; n++) tick(1);
      cmp1("interrupt", e, int_oe);
   endtask : wait_int
   task automatic open_rd(input logic [2:0] hi);
      pex_i2c_master_i.start();
      pex_i2c_master_i.write_byte({hi, adr_hi, adr_lo, 1'b1}, a);
      cmp1("read address ack", 1'b1, a);
   endtask : open_rd
   task automatic wr(input logic [2:0] hi, input int n, input int n_ok);
      pex_i2c_master_i.start();
      pex_i2c_master_i.write_byte({hi, adr_hi, adr_lo, 1'b0}, a);
      cmp1("write address ack", 1'b1, a);
      for (int k = 0; k < n; k++) begin
         pex_i2c_master_i.write_byte(wbuf[k], a);
         cmp1("data ack", k < n_ok, a);
      end
      pex_i2c_master_i.stop();
      tick(12);
   endtask : wr
   // ---------------------------------------------------------------
   // result watcher: oldest note against each received byte
   // ---------------------------------------------------------------
   always @(posedge clk_in) begin
      if (rx_valid === 1'b1) begin
         if (exp_q.size() == 0) cmp8("unexpected byte", 8'h00, 8'hXX);
         else cmp8("read byte", exp_q.pop_front(), rx_byte);
      end
   end
   initial begin
      tick(100000);
      cmp1("watchdog", 1'b1, 1'b0);
      report_and_stop();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n_in = 1'b0;
      hold = 1'b0;
      inp = 4'h0;
      ga_pin = 4'h0;
      gb_pin = 8'h00;
      adr_hi = 2'h0;
      adr_lo = 2'h0;
      void'($urandom(32'h39D8D628));
      tick(5);
      adr_hi <= 2'($urandom());
      adr_lo <= 2'($urandom());
      in_cur = 4'($urandom());
      inp <= in_cur;
      rst_n_in <= 1'b1;
      tick(6);
      cmp8("group a outputs", {4'h0, PEX_GA_OUT_RST}, {4'h0, ga_out});
      cmp8("group b outputs", PEX_GB_OUT_RST, gb_out);
      cmp1("interrupt", 1'b0, int_oe);
      cmp1("open drain data level", 1'b0, sda_o);
      cmp1("open drain interrupt level", 1'b0, int_n);
      $display("test reset done");
      // group a writes; last one enables every mask bit
      for (int k = 0; k < 2; k++) begin
         wbuf[0] = 8'($urandom());
         if (k == 1) wbuf[0][5:2] = 4'hF;
         wr(PEX_GA_ADDR_HI, 1, 1);
         cmp8("outputs", {4'h0, wbuf[0][7:6], wbuf[0][1:0]}, {4'h0, ga_out});
         cmp8("mask", {4'h0, wbuf[0][5:2]}, {4'h0, mask});
      end
      $display("test group a write done");
      for (int k = 0; k < 3; k++) wbuf[k] = 8'($urandom());
      wr(PEX_GB_ADDR_HI, 3, 3);
      cmp8("group b outputs", wbuf[2], gb_out);
      $display("test group b write done");
      // pins forced away from latches, changed before each ack
      cur = ~gb_out;
      gb_pin <= cur;
      open_rd(PEX_GB_ADDR_HI);
      for (int k = 0; k < 3; k++) begin
         exp_q.push_back(cur);
         cur = 8'($urandom());
         gb_pin <= cur;
         pex_i2c_master_i.read_byte(k < 2, d);
      end
      pex_i2c_master_i.stop();
      $display("test group b read done");
      // latched transition on a masked input
      inp <= in_cur ^ 4'h1;
      wait_int(1'b1);
      inp <= in_cur;
      tick(10);
      cmp1("interrupt held", 1'b1, int_oe);
      gp = 8'($urandom());
      ga_pin <= gp[3:0];
      open_rd(PEX_GA_ADDR_HI);
      cmp1("interrupt released", 1'b0, int_oe);
      exp_q.push_back({gp[3:2], in_cur, gp[1:0]});
      pex_i2c_master_i.read_byte(1'b1, d);
      exp_q.push_back({2'b00, 4'h1, 2'b00});
      pex_i2c_master_i.read_byte(1'b1, d);
      exp_q.push_back({gp[3:2], in_cur, gp[1:0]});
      in_cur = in_cur ^ 4'h4;
      inp <= in_cur;
      pex_i2c_master_i.read_byte(1'b1, d);
      cmp1("interrupt during read", 1'b0, int_oe);
      // second pair reports flags from before its own clear: none yet
      exp_q.push_back({2'b00, 4'h0, 2'b00});
      pex_i2c_master_i.read_byte(1'b0, d);
      cmp1("interrupt before stop", 1'b0, int_oe);
      pex_i2c_master_i.stop();
      wait_int(1'b1);
      $display("test group a read done");
      // foreign address: nothing acknowledged, nothing changed
      pex_i2c_master_i.start();
      pex_i2c_master_i.write_byte({3'b111, adr_hi, adr_lo, 1'b0}, a);
      cmp1("foreign address ack", 1'b0, a);
      pex_i2c_master_i.write_byte(8'h00, a);
      cmp1("foreign data ack", 1'b0, a);
      pex_i2c_master_i.stop();
      tick(12);
      cmp8("group b outputs", wbuf[2], gb_out);
      cmp1("interrupt kept", 1'b1, int_oe);
      $display("test foreign address done");
      // stalled drain: ninth byte refused, then eight drain in order
      hold <= 1'b1;
      d = wbuf[2];
      for (int k = 0; k < 9; k++) wbuf[k] = 8'($urandom());
      wr(PEX_GB_ADDR_HI, 9, PEX_FIFO_DEPTH);
      cmp8("held outputs", d, gb_out);
      hold <= 1'b0;
      tick(40);
      cmp8("drained outputs", wbuf[7], gb_out);
      $display("test fifo done");
      cmp8("pending notes", 8'h00, 8'(exp_q.size()));
      report_and_stop();
   end
endmodule : pex_access_bench
`default_nettype wire
